/* hw/tx_atm_user_cell_filter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tx_cell_filter_regs.svh"

// Operation
// - Cells from parity checker and insertion buffer both enter this filter stage.
// - Four filters judge every cell in parallel at the same time.
// - Each filter compares all four header bytes of the cell.
// - Control bit 3 enables each filter; 1 on, 0 off.
// - A disabled filter neither drops nor copies any cell.
// - An enabled filter acts on every cell per its control, pattern, check.
// - Copy bit 2 sends qualifying cells to the extraction memory port.
// - Discard bit 1 removes qualifying cells from the downstream path.
// - With discard clear, qualifying cells continue downstream.
// - Copy and discard are independent; both copies and drops the cell.
// - Sense bit 0: 1 acts on matching cells, 0 on non-matching.
// - Match criteria come from four pattern and four check registers.
// - One eight-bit pattern register per header byte, per filter.
// - Check bit 1 compares that header bit; 0 ignores it.
module tx_atm_user_cell_filter (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire tx_cell_filter_pkg::cell_beat_t cell_in,
  input wire logic cell_valid_in,
  output logic cell_ready_out,
  output var tx_cell_filter_pkg::cell_beat_t cell_out,
  output logic cell_valid_out,
  output var tx_cell_filter_pkg::cell_beat_t copy_out,
  output logic copy_valid_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);

  logic [`CTRL_WIDTH-1:0] ctrl [`NUM_FILTERS];
  logic [7:0] pattern [`NUM_FILTERS][`HDR_BYTES];
  logic [7:0] check [`NUM_FILTERS][`HDR_BYTES];
  logic [7:0] hdr [`HDR_BYTES];
  tx_cell_filter_pkg::filt_state_t state;
  logic [1:0] cnt;
  logic drop_q;
  logic copy_q;
  logic take;
  logic emit;
  tx_cell_filter_pkg::cell_beat_t emit_beat;
  logic [31:0] next_hdr;
  logic next_drop;
  logic next_copy;
  logic [7:0] next_rdata;

  function automatic logic [7:0] reg_at(input int f, input logic [7:0] base);
    reg_at = 8'(int'(base) + f * int'(`FLT_STRIDE));
  endfunction : reg_at

  function automatic logic hdr_match(input logic [31:0] h, input logic [31:0] p,
                                     input logic [31:0] c);
    hdr_match = (((h ^ p) & c) == 32'h0000_0000);
  endfunction : hdr_match

  // Register writes
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int f = 0; f < `NUM_FILTERS; f++) begin
        ctrl[f] <= `CTRL_RESET;
        for (int b = 0; b < `HDR_BYTES; b++) begin
          pattern[f][b] <= `PAT_RESET;
          check[f][b] <= `CHK_RESET;
        end
      end
    end else if (reg_wr_in) begin
      for (int f = 0; f < `NUM_FILTERS; f++) begin
        if (reg_addr_in == reg_at(f, `FLT_CTRL_OFS)) begin
          ctrl[f] <= reg_wdata_in[`CTRL_WIDTH-1:0];
        end
        for (int b = 0; b < `HDR_BYTES; b++) begin
          if (reg_addr_in == reg_at(f, 8'(int'(`FLT_PAT_OFS) + b))) begin
            pattern[f][b] <= reg_wdata_in;
          end
          if (reg_addr_in == reg_at(f, 8'(int'(`FLT_CHK_OFS) + b))) begin
            check[f][b] <= reg_wdata_in;
          end
        end
      end
    end
  end

  // Register read mux; unused control bits and unmapped offsets read zero
  always_comb begin
    next_rdata = `RDATA_IDLE;
    for (int f = 0; f < `NUM_FILTERS; f++) begin
      if (reg_addr_in == reg_at(f, `FLT_CTRL_OFS)) begin
        next_rdata = {{(8 - `CTRL_WIDTH){1'b0}}, ctrl[f]};
      end
      for (int b = 0; b < `HDR_BYTES; b++) begin
        if (reg_addr_in == reg_at(f, 8'(int'(`FLT_PAT_OFS) + b))) begin
          next_rdata = pattern[f][b];
        end
        if (reg_addr_in == reg_at(f, 8'(int'(`FLT_CHK_OFS) + b))) begin
          next_rdata = check[f][b];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= `RDATA_IDLE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // Cell decision from the full header as its last byte arrives
  always_comb begin
    next_hdr = {hdr[0], hdr[1], hdr[2], cell_in.data};
    next_drop = 1'b0;
    next_copy = 1'b0;
    for (int f = 0; f < `NUM_FILTERS; f++) begin
      if (ctrl[f][`CTRL_ENABLE_BIT] &&
          (hdr_match(next_hdr, {pattern[f][0], pattern[f][1], pattern[f][2], pattern[f][3]},
                     {check[f][0], check[f][1], check[f][2], check[f][3]})
           == ctrl[f][`CTRL_SENSE_BIT])) begin
        next_drop = next_drop | ctrl[f][`CTRL_DISCARD_BIT];
        next_copy = next_copy | ctrl[f][`CTRL_COPY_BIT];
      end
    end
  end

  // Stream handshake: stall input while the held header is replayed
  assign cell_ready_out = (state != tx_cell_filter_pkg::ST_REPLAY);
  assign take = cell_valid_in && cell_ready_out;

  always_comb begin
    emit = 1'b0;
    emit_beat = '0;
    case (state)
      tx_cell_filter_pkg::ST_REPLAY: begin
        emit = 1'b1;
        emit_beat.data = hdr[cnt];
        emit_beat.sop = (cnt == `HDR_FIRST);
        emit_beat.eop = 1'b0;
      end
      tx_cell_filter_pkg::ST_BODY: begin
        emit = take;
        emit_beat.data = cell_in.data;
        emit_beat.sop = 1'b0;
        emit_beat.eop = cell_in.eop;
      end
      default: begin
        emit = 1'b0;
      end
    endcase
  end

  // Header capture and sequencing
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= tx_cell_filter_pkg::ST_HEADER;
      cnt <= `HDR_FIRST;
      drop_q <= 1'b0;
      copy_q <= 1'b0;
      for (int b = 0; b < `HDR_BYTES; b++) begin
        hdr[b] <= 8'h00;
      end
    end else begin
      case (state)
        tx_cell_filter_pkg::ST_HEADER: begin
          if (take && (cell_in.sop || cnt != `HDR_FIRST)) begin
            hdr[cnt] <= cell_in.data;
            cnt <= 2'(cnt + 2'h1);
            if (cell_in.sop && cnt != `HDR_FIRST) begin
              hdr[0] <= cell_in.data;
              cnt <= 2'h1;
            end else if (cnt == `HDR_LAST) begin
              drop_q <= next_drop;
              copy_q <= next_copy;
              state <= tx_cell_filter_pkg::ST_REPLAY;
            end
          end
        end
        tx_cell_filter_pkg::ST_REPLAY: begin
          cnt <= 2'(cnt + 2'h1);
          if (cnt == `HDR_LAST) begin
            state <= tx_cell_filter_pkg::ST_BODY;
          end
        end
        tx_cell_filter_pkg::ST_BODY: begin
          if (take && cell_in.eop) begin
            state <= tx_cell_filter_pkg::ST_HEADER;
          end
        end
        default: begin
          state <= tx_cell_filter_pkg::ST_HEADER;
          cnt <= `HDR_FIRST;
        end
      endcase
    end
  end

  // Downstream path toward HEC insertion
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cell_out <= '0;
      cell_valid_out <= 1'b0;
    end else begin
      cell_out <= emit_beat;
      cell_valid_out <= emit && !drop_q;
    end
  end

  // Replica path toward the extraction memory
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      copy_out <= '0;
      copy_valid_out <= 1'b0;
    end else begin
      copy_out <= emit_beat;
      copy_valid_out <= emit && copy_q;
    end
  end

endmodule : tx_atm_user_cell_filter
`default_nettype wire

/* hw/tx_cell_filter_pkg.sv */
package tx_cell_filter_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
  } cell_beat_t;

  typedef enum logic [1:0] {
    ST_HEADER = 2'b00,
    ST_REPLAY = 2'b01,
    ST_BODY = 2'b11
  } filt_state_t;

endpackage : tx_cell_filter_pkg

/* hw/tx_cell_filter_regs.svh */
`ifndef TX_CELL_FILTER_REGS_SVH
`define TX_CELL_FILTER_REGS_SVH

// Register offsets within the block page (filter 0), plus stride between filters
`define FLT_CTRL_OFS 8'h43
`define FLT_PAT_OFS 8'h44
`define FLT_CHK_OFS 8'h48
`define FLT_STRIDE 8'h10

// Control register fields
`define CTRL_SENSE_BIT 0
`define CTRL_DISCARD_BIT 1
`define CTRL_COPY_BIT 2
`define CTRL_ENABLE_BIT 3
`define CTRL_WIDTH 4

// Reset values
`define CTRL_RESET 4'h0
`define PAT_RESET 8'h00
`define CHK_RESET 8'h00
`define RDATA_IDLE 8'h00

// Filter count and cell header layout
`define NUM_FILTERS 4
`define HDR_BYTES 4
`define HDR_LAST 2'h3
`define HDR_FIRST 2'h0

`endif

/* tb/cell_source.sv */
`timescale 1ns/100ps
`default_nettype none
module cell_source (
  input wire logic clk_in,
  input wire logic ready_in,
  output var tx_cell_filter_pkg::cell_beat_t beat_out,
  output logic valid_out
);
  initial begin
    beat_out = 10'h000;
    valid_out = 1'b0;
  end
  // Holds each byte until taken
  task automatic put(input logic [7:0] d, input logic s, input logic e);
    beat_out = '{data: d, sop: s, eop: e};
    valid_out = 1'b1;
    while (!ready_in) @(negedge clk_in);
    @(negedge clk_in);
  endtask : put
  task automatic send(input logic [31:0] h, input int n);
    for (int i = 0; i < 4 + n; i++) begin
      put(i < 4 ? h[31 - 8 * i -: 8] : 8'(i), i == 0, i == 3 + n);
    end
    valid_out = 1'b0;
    beat_out = ~beat_out;
  endtask : send
endmodule : cell_source
`default_nettype wire

/* tb/filter_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module filter_asserts (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire tx_cell_filter_pkg::cell_beat_t cell_in,
  input wire logic cell_valid_in,
  input wire logic cell_ready_out,
  input wire tx_cell_filter_pkg::cell_beat_t cell_out,
  input wire logic cell_valid_out,
  input wire tx_cell_filter_pkg::cell_beat_t copy_out,
  input wire logic copy_valid_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence replay_s;
    !cell_ready_out [*4] ##1 cell_ready_out;
  endsequence
  replay_len_a: assert property ($fell(cell_ready_out) |-> replay_s)
    else $error("replay window length wrong");
  first_sop_a: assert property ($fell(cell_ready_out) ##1 cell_valid_out |-> cell_out.sop)
    else $error("first header byte lacks sop");
  body_pass_a: assert property (cell_valid_out && $past(cell_ready_out) |-> cell_out == $past(cell_in))
    else $error("body byte changed");
  out_cause_a: assert property (cell_valid_out |-> $past(cell_valid_in) || !$past(cell_ready_out))
    else $error("output byte without input");
  copy_cause_a: assert property (copy_valid_out |-> $past(cell_valid_in) || !$past(cell_ready_out))
    else $error("copy byte without input");
  copy_same_a: assert property (copy_valid_out && cell_valid_out |-> copy_out == cell_out)
    else $error("copy differs from passed byte");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without read");
  ctrl_unused_a: assert property (reg_rd_in && reg_addr_in[3:0] == 4'h3 |=> reg_rdata_out[7:4] == 4'h0)
    else $error("control upper bits not zero");
  unmapped_a: assert property (reg_rd_in && reg_addr_in[3:0] < 4'h3 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : filter_asserts
bind tx_atm_user_cell_filter filter_asserts chk_u (.ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in), .cell_in(cell_in), .cell_valid_in(cell_valid_in),
  .cell_ready_out(cell_ready_out), .cell_out(cell_out), .cell_valid_out(cell_valid_out),
  .copy_out(copy_out), .copy_valid_out(copy_valid_out), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
`default_nettype wire

/* tb/test_tx_atm_user_cell_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module test_tx_atm_user_cell_filter;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  tx_cell_filter_pkg::cell_beat_t cell_in, cell_out, copy_out;
  logic cell_valid_in, cell_ready_out, cell_valid_out, copy_valid_out;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  int num_errors = 0;
  int checked = 0;
  int npass = 0;
  int ncopy = 0;
  int cycles = 0;
  logic [7:0] first_seen = 8'h00;
  logic [7:0] last_seen = 8'h00;
  logic [7:0] ctl [7] = '{8'h07, 8'h0d, 8'h0b, 8'h0e, 8'h0a, 8'h0c, 8'h0b};
  logic [31:0] msk [7] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'hffffffff, 32'h1};
  logic [7:0] cm [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hfe};
  logic [1:0] want [7] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
  tx_atm_user_cell_filter dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .cell_in(cell_in), .cell_valid_in(cell_valid_in), .cell_ready_out(cell_ready_out),
    .cell_out(cell_out), .cell_valid_out(cell_valid_out), .copy_out(copy_out),
    .copy_valid_out(copy_valid_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));
  cell_source src_u (.clk_in(ref_clk_in), .ready_in(cell_ready_out),
    .beat_out(cell_in), .valid_out(cell_valid_in));
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic final_report();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    npass <= npass + int'(cell_valid_out === 1'b1);
    ncopy <= ncopy + int'(copy_valid_out === 1'b1);
    if (cell_valid_out === 1'b1 && cell_out.sop === 1'b1) begin
      first_seen <= cell_out.data;
    end
    if (cell_valid_out === 1'b1 && cell_out.eop === 1'b1) begin
      last_seen <= cell_out.data;
    end
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
    @(negedge ref_clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    chk(reg_rdata_out, exp);
    @(negedge ref_clk_in);
  endtask : rd
  initial begin
    logic [31:0] p;
    logic [7:0] b;
    int p0;
    int c0;
    repeat (16) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    rd(8'h43, 8'h00);
    wr(8'h73, 8'hff);
    rd(8'h73, 8'h0f);
    wr(8'h5a, 8'ha5);
    rd(8'h5a, 8'ha5);
    rd(8'h40, 8'h00);
    wr(8'h4b, 8'h3c);
    rd(8'h4b, 8'h3c);
    for (int i = 0; i < 7; i++) begin
      b = 8'h40 + 8'(16 * (i % 4));
      p = 32'h12345678 ^ msk[i];
      for (int j = 0; j < 4; j++) begin
        wr(8'h43 + 8'(16 * j), 8'h00);
        wr(b + 8'(4 + j), p[31 - 8 * j -: 8]);
        wr(b + 8'(8 + j), cm[i]);
      end
      wr(b + 8'h03, ctl[i]);
      p0 = npass;
      c0 = ncopy;
      src_u.send(32'h12345678, 4);
      repeat (2) @(negedge ref_clk_in);
      chk(8'(npass - p0), {4'h0, want[i][1], 3'h0});
      chk(8'(ncopy - c0), {4'h0, want[i][0], 3'h0});
      if (want[i][1]) begin
        chk(first_seen, 8'h12);
        chk(last_seen, 8'h07);
      end
    end
    final_report();
  end
endmodule : test_tx_atm_user_cell_filter
`default_nettype wire
